// file: logic/ueb_pkg.sv
package ueb_pkg;
    // Register addresses
    localparam logic [15:0] UEB_ADDR_ERR_STATUS = 16'hff71;
    localparam logic [15:0] UEB_ADDR_CLK_SELECT = 16'hff73;
    localparam logic [15:0] UEB_ADDR_RX_BUFFER = 16'hff74;

    // Reset values
    localparam logic [7:0] UEB_ERR_STATUS_RESET = 8'h00;
    localparam logic [3:0] UEB_SOURCE_SEL_RESET = 4'h0;

    // Field positions
    localparam int UEB_PARITY_ERR_BIT = 2;
    localparam int UEB_FRAME_ERR_BIT = 1;
    localparam int UEB_OVERRUN_ERR_BIT = 0;
    localparam int UEB_SOURCE_SEL_LSB = 4;

    // Source selection codes
    localparam logic [3:0] UEB_SEL_INT_LAST = 4'h7;
    localparam logic [3:0] UEB_SEL_EXT_PIN = 4'h8;

    // Division counts and shift clock idle level
    localparam logic [3:0] UEB_UART_OVERSAMPLE_LAST = 4'hf;
    localparam logic [7:0] UEB_PRESCALE_FULL = 8'hff;
    localparam logic [7:0] UEB_PRESCALE_RESET = 8'h00;
    localparam logic SHIFT_CLK_IDLE = 1'b1;

    // Parity mode codes {parity_mode_hi, parity_mode_lo}
    localparam logic [1:0] UEB_PARITY_NONE = 2'h0;
    localparam logic [1:0] UEB_PARITY_ZERO = 2'h1;
    localparam logic [1:0] UEB_PARITY_ODD = 2'h2;
    localparam logic [1:0] UEB_PARITY_EVEN = 2'h3;

    // Receive buffer FIFO shape
    localparam int UEB_FIFO_WIDTH = 8;
    localparam int UEB_FIFO_DEPTH = 16;

    // One completed reception from the receive shifter
    typedef struct packed {
        logic done;
        logic [7:0] char_data;
        logic parity_bit;
        logic stop_bit;
    } ueb_rx_event_type;

    typedef struct packed {
        logic parity_err_flag;
        logic frame_err_flag;
        logic overrun_err_flag;
    } ueb_status_type;
endpackage : ueb_pkg

// file: logic/ueb_top.sv
// Overview of operation
// RL1 - Error status is 8-bit read-only, reset zero, bits 7..3 zero, parity/frame/overrun.
// RL2 - In 3-wire mode the error status content carries no meaning.
// RL3 - Parity flag set when received parity disagrees with computed parity.
// RL4 - Framing flag set when no valid stop bit is seen.
// RL5 - Only the first stop bit is checked, even with two stop bits.
// RL6 - Overrun flag set when a reception completes before the buffer was read; the code sets it only when all 16 buffer entries are unread.
// RL7 - Until software reads the buffer, every later reception raises overrun again.
// RL8 - Clock select is 8-bit read/write, reset zero, upper nibble field, lower zero.
// RL9 - Codes 0..7 divide system clock by 2^(n), the code by 2^(n+1); code 8 picks external pin.
// RL10 - Software picks the external pin only in UART mode.
// RL11 - Software must not write clock select during a transfer.
// RL12 - UART internal bit rate is system clock over 2^(n+1) times 8; the code divides by 2^(n+1) times 16.
// RL13 - UART external bit rate is the pin clock over 16.
// RL14 - 3-wire internal shift clock is system clock over 2^(n+1); the code gives system clock over 2^(n+2).
// RL15 - External 3-wire shift clock ignores the clock select register.
// RL16 - Software avoids the too-fast settings of n for the system clock.
// RL17 - Software sets the port 2 pin to input when external pin is chosen.
// RL18 - Zero-parity mode skips the parity check and never flags parity.
// RL19 - All three flags are replaced at the end of each reception.
`timescale 1ns/10ps

module ueb_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 16
) (
    input wire logic clock, // System clock
    input wire logic nrst, // Asynchronous reset, active low
    input wire logic in_valid, // Write request
    output logic in_ready, // Space available
    input wire logic [WIDTH-1:0] in_data, // Write data
    output logic out_valid, // Data available
    input wire logic out_ready, // Read acknowledge
    output logic [WIDTH-1:0] out_data // Head entry
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0] wr_ptr;
    logic [AW-1:0] rd_ptr;
    logic [AW:0] count;
    wire push = in_valid && in_ready;
    wire pop = out_valid && out_ready;

    assign in_ready = count != (AW+1)'(DEPTH);
    assign out_valid = count != '0;
    assign out_data = mem[rd_ptr];

    always_ff @(posedge clock) begin
        if (push) begin
            mem[wr_ptr] <= in_data;
        end
    end

    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            wr_ptr <= '0;
            rd_ptr <= '0;
            count <= '0;
        end else begin
            wr_ptr <= push ? wr_ptr + AW'(1) : wr_ptr;
            rd_ptr <= pop ? rd_ptr + AW'(1) : rd_ptr;
            count <= count + (AW+1)'(push) - (AW+1)'(pop);
        end
    end
endmodule : ueb_fifo

module ueb_top (
    input wire logic clock, // System clock, 50 MHz
    input wire logic nrst, // Asynchronous reset, active low
    input wire logic [15:0] reg_addr, // Register address
    input wire logic reg_wr, // Byte write strobe
    input wire logic reg_rd, // Read strobe
    input wire logic [7:0] reg_wdata, // Write data
    output logic [7:0] reg_rdata, // Read data, one cycle after strobe
    input wire logic uart_mode, // UART mode active
    input wire logic three_wire_mode, // 3-wire synchronous mode active
    input wire logic shift_clk_internal, // 3-wire clock from generator
    input wire logic parity_mode_hi, // Parity mode, high bit
    input wire logic parity_mode_lo, // Parity mode, low bit
    input wire logic char_len_8, // Eight-bit characters
    input wire ueb_pkg::ueb_rx_event_type rx_event, // Completed reception
    output logic rx_buf_ready, // Receive buffer has room
    output logic rx_buf_valid, // Receive buffer holds a character
    input wire logic ext_baud_clock_pin, // External baud clock pin
    output logic uart_sample_tick, // Oversampling tick, 16 per bit
    output logic uart_bit_tick, // One tick per bit period
    output logic serial_shift_clock_out, // 3-wire shift clock drive
    output logic serial_shift_clock_oe // 3-wire shift clock enable
);
    import ueb_pkg::*;

    ueb_status_type status;
    logic [3:0] source_sel;
    logic [7:0] prescale;
    logic [3:0] oversample;
    logic ext_meta;
    logic ext_sync;
    logic ext_prev;
    logic shift_clk;
    logic [7:0] rdata;

    // Register decode
    wire sel_status = reg_addr == UEB_ADDR_ERR_STATUS;
    wire sel_clk = reg_addr == UEB_ADDR_CLK_SELECT;
    wire sel_rxbuf = reg_addr == UEB_ADDR_RX_BUFFER;
    wire wr_clk = reg_wr && sel_clk;
    wire rd_rxbuf = reg_rd && sel_rxbuf;

    // Receive checks
    wire [1:0] parity_mode = {parity_mode_hi, parity_mode_lo};
    wire [7:0] char_bits = char_len_8 ? rx_event.char_data : {1'b0, rx_event.char_data[6:0]};
    wire parity_sum = ^char_bits ^ rx_event.parity_bit;
    wire parity_bad = (parity_mode == UEB_PARITY_ODD && !parity_sum) ||
                      (parity_mode == UEB_PARITY_EVEN && parity_sum); // [RL3] [RL18]
    wire frame_bad = !rx_event.stop_bit; // [RL4] [RL5]
    wire rx_done = rx_event.done && uart_mode; // [RL2]
    wire fifo_in_ready;
    wire [7:0] fifo_out_data;

    // Clock generation
    wire sel_internal = source_sel <= UEB_SEL_INT_LAST;
    wire sel_external = source_sel == UEB_SEL_EXT_PIN;
    wire [7:0] div_mask = UEB_PRESCALE_FULL >> (UEB_SEL_INT_LAST[2:0] - source_sel[2:0]);
    wire int_tick = sel_internal && ((prescale & div_mask) == div_mask); // [RL9]
    wire ext_rise = ext_sync && !ext_prev;
    wire source_tick = sel_internal ? int_tick : (sel_external && ext_rise); // [RL9]
    wire shift_active = three_wire_mode && shift_clk_internal; // [RL15]

    assign uart_sample_tick = uart_mode && source_tick; // [RL13]
    assign uart_bit_tick = uart_sample_tick &&
                           oversample == UEB_UART_OVERSAMPLE_LAST; // [RL12] [RL13]
    assign serial_shift_clock_out = shift_clk;
    assign serial_shift_clock_oe = shift_active; // [RL15]
    assign rx_buf_ready = fifo_in_ready;
    assign reg_rdata = rdata;

    ueb_fifo #(
        .WIDTH(UEB_FIFO_WIDTH),
        .DEPTH(UEB_FIFO_DEPTH)
    ) u_rx_fifo (
        .clock(clock),
        .nrst(nrst),
        .in_valid(rx_done),
        .in_ready(fifo_in_ready),
        .in_data(rx_event.char_data),
        .out_valid(rx_buf_valid),
        .out_ready(rd_rxbuf),
        .out_data(fifo_out_data)
    );

    wire [7:0] status_byte = {5'h00, status.parity_err_flag, status.frame_err_flag,
                              status.overrun_err_flag}; // [RL1]
    wire [7:0] next_rdata = sel_status ? status_byte :
                            sel_clk ? {source_sel, 4'h0} : // [RL8]
                            sel_rxbuf ? fifo_out_data : 8'h00;

    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            status <= ueb_status_type'(UEB_ERR_STATUS_RESET[2:0]); // [RL1]
        end else if (rx_done) begin
            status.parity_err_flag <= parity_bad; // [RL3] [RL19]
            status.frame_err_flag <= frame_bad; // [RL4] [RL19]
            status.overrun_err_flag <= !fifo_in_ready; // [RL6] [RL7] [RL19]
        end
    end

    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            source_sel <= UEB_SOURCE_SEL_RESET; // [RL8]
        end else if (wr_clk) begin
            source_sel <= reg_wdata[UEB_SOURCE_SEL_LSB +: 4]; // [RL8]
        end
    end

    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            rdata <= 8'h00;
        end else if (reg_rd) begin
            rdata <= next_rdata;
        end
    end

    // Free-running prescaler, divider taps chosen by source_sel
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            prescale <= UEB_PRESCALE_RESET;
        end else begin
            prescale <= prescale + 8'h01;
        end
    end

    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            ext_meta <= 1'b0;
            ext_sync <= 1'b0;
            ext_prev <= 1'b0;
        end else begin
            ext_meta <= ext_baud_clock_pin;
            ext_sync <= ext_meta;
            ext_prev <= ext_sync;
        end
    end

    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            oversample <= 4'h0;
        end else if (uart_sample_tick) begin
            oversample <= oversample + 4'h1; // [RL12] [RL13]
        end
    end

    // Toggling on every internal tick doubles the divider period
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            shift_clk <= SHIFT_CLK_IDLE;
        end else if (!shift_active) begin
            shift_clk <= SHIFT_CLK_IDLE;
        end else if (int_tick) begin
            shift_clk <= !shift_clk; // [RL14]
        end
    end

    sequence s_rx_full;
        rx_done && !fifo_in_ready;
    endsequence

    sequence s_rx_room;
        rx_done && fifo_in_ready;
    endsequence

    a_status_high_zero: assert property (@(posedge clock) disable iff (!nrst) // [RL1]
        reg_rd && sel_status |=> reg_rdata[7:3] == 5'h00)
        else $error("status reserved bits not zero");
    a_parity_flag: assert property (@(posedge clock) disable iff (!nrst) // [RL3]
        rx_done |=> status.parity_err_flag == $past(parity_bad))
        else $error("parity flag wrong");
    a_frame_flag: assert property (@(posedge clock) disable iff (!nrst) // [RL4]
        rx_done |=> status.frame_err_flag == !$past(rx_event.stop_bit))
        else $error("framing flag wrong");
    a_overrun_set: assert property (@(posedge clock) disable iff (!nrst) // [RL6]
        s_rx_full |=> status.overrun_err_flag)
        else $error("overrun not raised");
    a_overrun_repeat: assert property (@(posedge clock) disable iff (!nrst) // [RL7]
        s_rx_full ##1 (!rd_rxbuf && !rx_done)[*3] ##1 rx_done |=> status.overrun_err_flag)
        else $error("overrun not repeated");
    a_overrun_clear: assert property (@(posedge clock) disable iff (!nrst) // [RL19]
        s_rx_room |=> !status.overrun_err_flag)
        else $error("overrun not replaced");
    a_select_low_zero: assert property (@(posedge clock) disable iff (!nrst) // [RL8]
        reg_rd && sel_clk |=> reg_rdata[3:0] == 4'h0)
        else $error("select low nibble not zero");
    a_prohibited_quiet: assert property (@(posedge clock) disable iff (!nrst) // [RL9]
        source_sel > UEB_SEL_EXT_PIN |-> !source_tick)
        else $error("tick on prohibited code");
    a_fastest_bit: assert property (@(posedge clock) disable iff (!nrst) // [RL12]
        uart_bit_tick |=> !uart_bit_tick [*8])
        else $error("bit tick too early");
    a_ext_tick: assert property (@(posedge clock) disable iff (!nrst) // [RL13]
        uart_sample_tick && sel_external |-> ext_sync && !$past(ext_sync))
        else $error("external tick without pin edge");
    a_shift_toggle: assert property (@(posedge clock) disable iff (!nrst) // [RL14]
        shift_active && int_tick ##1 shift_active |-> shift_clk != $past(shift_clk))
        else $error("shift clock did not toggle");
    a_ext_sck_idle: assert property (@(posedge clock) disable iff (!nrst) // [RL15]
        !shift_clk_internal |-> !serial_shift_clock_oe)
        else $error("shift clock driven when external");
    a_zero_parity: assert property (@(posedge clock) disable iff (!nrst) // [RL18]
        rx_done && parity_mode == UEB_PARITY_ZERO |=> !status.parity_err_flag)
        else $error("parity flagged in zero mode");
endmodule : ueb_top

// file: testbench/tb_uart_error_status_baud_gen.sv
`timescale 1ns/10ps

module tb_uart_error_status_baud_gen;
    import ueb_pkg::*;
    logic clock = 1'b0;
    logic nrst = 1'b0;
    logic [15:0] reg_addr = 16'h0000;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic [7:0] reg_wdata = 8'h00;
    logic uart_mode = 1'b0;
    logic three_wire_mode = 1'b0;
    logic shift_clk_internal = 1'b0;
    logic parity_mode_hi = 1'b0;
    logic parity_mode_lo = 1'b0;
    logic char_len_8 = 1'b1;
    logic ext_en = 1'b0;
    logic rd_pend = 1'b0;
    logic shift_prev = 1'b1;
    ueb_rx_event_type rx_event;
    logic [7:0] reg_rdata;
    logic rx_buf_ready, rx_buf_valid, ext_baud_clock_pin, uart_sample_tick, uart_bit_tick;
    logic serial_shift_clock_out, serial_shift_clock_oe;
    logic [7:0] exp_q[$];
    logic [7:0] ch;
    logic p, s, e;
    int error_cnt = 0;
    int n_checks = 0;
    int samp_cnt = 0, samp_gap = 0, bit_cnt = 0, bit_gap = 0, sh_cnt = 0, sh_gap = 0;

    always #10 clock = ~clock;

    ueb_top i_ueb_top (.clock(clock), .nrst(nrst), .reg_addr(reg_addr), .reg_wr(reg_wr),
        .reg_rd(reg_rd), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .uart_mode(uart_mode),
        .three_wire_mode(three_wire_mode), .shift_clk_internal(shift_clk_internal),
        .parity_mode_hi(parity_mode_hi), .parity_mode_lo(parity_mode_lo),
        .char_len_8(char_len_8), .rx_event(rx_event), .rx_buf_ready(rx_buf_ready),
        .rx_buf_valid(rx_buf_valid), .ext_baud_clock_pin(ext_baud_clock_pin),
        .uart_sample_tick(uart_sample_tick), .uart_bit_tick(uart_bit_tick),
        .serial_shift_clock_out(serial_shift_clock_out),
        .serial_shift_clock_oe(serial_shift_clock_oe));

    ueb_partner i_ueb_partner (.clock(clock), .ext_en(ext_en), .rx_event(rx_event),
        .ext_baud_clock_pin(ext_baud_clock_pin));

    task automatic check(input logic [15:0] seen, input logic [15:0] exp, input string msg);
        n_checks++;
        if (seen !== exp) begin
            error_cnt++;
            $display("unexpected at %0t: %s seen %h expected %h", $time, msg, seen, exp);
        end
    endtask : check

    task automatic print_verdict;
        $display("checks %0d mismatches %0d", n_checks, error_cnt);
        if (error_cnt == 0 && n_checks > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask : print_verdict

    task automatic rd(input logic [15:0] a, input logic [7:0] e);
        @(posedge clock);
        reg_rd <= 1'b1;
        reg_addr <= a;
        exp_q.push_back(e);
        @(posedge clock);
        reg_rd <= 1'b0;
    endtask : rd

    task automatic wr(input logic [15:0] a, input logic [7:0] d);
        @(posedge clock);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge clock);
        reg_wr <= 1'b0;
    endtask : wr

    function automatic logic exp_perr(input logic [1:0] m, input logic [7:0] c, input logic pb);
        logic ones;
        ones = ^c ^ pb;
        return (m == UEB_PARITY_ODD) ? ~ones : (m == UEB_PARITY_EVEN) ? ones : 1'b0;
    endfunction : exp_perr

    // Read data lands one cycle after the strobe; compare with the oldest note
    always @(posedge clock) begin
        if (rd_pend) check(reg_rdata, exp_q.pop_front(), "read data");
        rd_pend <= reg_rd;
    end

    // Cycles between successive ticks and shift clock rises
    always @(posedge clock) begin
        samp_cnt++;
        bit_cnt++;
        sh_cnt++;
        if (uart_sample_tick === 1'b1) begin
            samp_gap = samp_cnt;
            samp_cnt = 0;
        end
        if (uart_bit_tick === 1'b1) begin
            bit_gap = bit_cnt;
            bit_cnt = 0;
        end
        if (shift_prev === 1'b0 && serial_shift_clock_out === 1'b1) begin
            sh_gap = sh_cnt;
            sh_cnt = 0;
        end
        shift_prev = serial_shift_clock_out;
    end

    initial begin
        ch = 8'($urandom(32'hf7b8a463));
        repeat (8) @(posedge clock);
        nrst <= 1'b1;
        rd(UEB_ADDR_ERR_STATUS, UEB_ERR_STATUS_RESET);
        rd(UEB_ADDR_CLK_SELECT, 8'h00);
        rd(16'h1234, 8'h00);
        wr(UEB_ADDR_ERR_STATUS, 8'hff);
        wr(UEB_ADDR_CLK_SELECT, 8'h5f);
        rd(UEB_ADDR_ERR_STATUS, 8'h00);
        rd(UEB_ADDR_CLK_SELECT, 8'h50);
        // Prohibited code stays selected through the reception tests: no ticks may appear
        wr(UEB_ADDR_CLK_SELECT, 8'h90);
        rd(UEB_ADDR_CLK_SELECT, 8'h90);
        $display("test registers done");
        uart_mode <= 1'b1;
        for (int i = 0; i < 8; i++) begin
            {parity_mode_hi, parity_mode_lo} <= i[1:0];
            char_len_8 <= i[2];
            ch = 8'($urandom);
            p = 1'($urandom);
            s = 1'($urandom);
            i_ueb_partner.send(ch, p, s);
            // Seven-bit characters leave bit 7 out of the parity sum
            e = exp_perr(i[1:0], ch & (i[2] ? 8'hff : 8'h7f), p);
            rd(UEB_ADDR_ERR_STATUS, {5'h00, e, ~s, 1'b0});
            rd(UEB_ADDR_RX_BUFFER, ch);
        end
        $display("test reception flags done");
        {parity_mode_hi, parity_mode_lo} <= UEB_PARITY_NONE;
        for (int i = 0; i < 18; i++) begin
            if (i == 16) #1 check(rx_buf_ready, 16'h0, "buffer full");
            i_ueb_partner.send(8'(i), 1'b0, i != 17);
            if (i >= 16) rd(UEB_ADDR_ERR_STATUS, {6'h00, i == 17, 1'b1});
        end
        for (int i = 0; i < 16; i++) rd(UEB_ADDR_RX_BUFFER, 8'(i));
        #1 check(rx_buf_valid, 16'h0, "buffer empty");
        i_ueb_partner.send(8'h5a, 1'b0, 1'b1);
        rd(UEB_ADDR_ERR_STATUS, 8'h00);
        check(16'(samp_gap), 16'h0000, "tick on prohibited code");
        $display("test overrun done");
        uart_mode <= 1'b0;
        for (int c = 2; c < 8; c++) begin
            wr(UEB_ADDR_CLK_SELECT, 8'(c << 4));
            uart_mode <= 1'b1;
            samp_gap = 0;
            bit_gap = 0;
            repeat (96 << c) @(posedge clock);
            check(16'(samp_gap), 16'(2 << c), "sample tick");
            check(16'(bit_gap), 16'(32 << c), "bit tick");
            uart_mode <= 1'b0;
        end
        wr(UEB_ADDR_CLK_SELECT, 8'h80);
        uart_mode <= 1'b1;
        ext_en <= 1'b1;
        repeat (600) @(posedge clock);
        check(16'(samp_gap), 16'd9, "pin sample tick");
        check(16'(bit_gap), 16'd144, "pin bit tick");
        ext_en <= 1'b0;
        uart_mode <= 1'b0;
        three_wire_mode <= 1'b1;
        for (int c = 1; c < 8; c++) begin
            wr(UEB_ADDR_CLK_SELECT, 8'(c << 4));
            shift_clk_internal <= 1'b1;
            sh_gap = 0;
            repeat (16 << c) @(posedge clock);
            check(16'(sh_gap), 16'(4 << c), "shift clock");
            check(serial_shift_clock_oe, 16'h1, "shift enable");
            shift_clk_internal <= 1'b0;
        end
        repeat (4) @(posedge clock);
        check(serial_shift_clock_oe, 16'h0, "external shift clock");
        $display("test clock generation done");
        print_verdict();
    end

    initial begin
        repeat (80000) @(posedge clock);
        error_cnt++;
        $display("unexpected at %0t: watchdog expired", $time);
        print_verdict();
    end
endmodule : tb_uart_error_status_baud_gen

// file: testbench/ueb_partner.sv
`timescale 1ns/10ps

module ueb_partner (
    input wire logic clock, // System clock
    input wire logic ext_en, // Run the external baud clock
    output ueb_pkg::ueb_rx_event_type rx_event, // Completed reception
    output logic ext_baud_clock_pin // External baud clock
);
    import ueb_pkg::*;
    // Pin clock of 180 ns period, off the system clock's phase, low when stopped
    initial begin
        rx_event = '0;
        ext_baud_clock_pin = 1'b0;
        #7;
        forever begin
            #90;
            ext_baud_clock_pin = ext_en ? ~ext_baud_clock_pin : 1'b0;
        end
    end
    task automatic send(input logic [7:0] c, input logic p, input logic s);
        @(posedge clock);
        rx_event <= '{done: 1'b1, char_data: c, parity_bit: p, stop_bit: s};
        @(posedge clock);
        rx_event.done <= 1'b0;
    endtask : send
endmodule : ueb_partner
